/* acs_regs.sv */
// Clock status, sticky error, system control and serial format registers
//
// Function
// - Detect sample rate, report in bits 7:5
// - Report master clock ratio in bits 4:2
// - 64x and 128x only at 44.1/48 kHz
// - 192x only at 32, 44.1, 48 kHz
// - Read-only eight-bit firmware revision code
// - Error flags sticky, cleared only by zero writes
// - Error bit layout: clocks, slip, clip, protection
// - Master clock count change sets error
// - Bit clock count change sets error
// - Word clock frequency change sets error
// - Word clock phase drift sets frame slip
// - Control bit 7 enables dc-blocking filter
// - Control bit 5 picks soft or hard unmute
// - Soft unmute lasts the volume ramp time
// - Control bits 1:0 select de-emphasis curve
// - Format register decodes nine serial modes
// - Reset format is 24-bit I2S
// - Coefficients are signed 3.23 fixed point
`timescale 1ns/1ps
module acs_regs
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Serial control port register access
   input  wire acs_req_s    req,
   output logic [7:0]       rdata,
   // Serial audio clock pins
   input  wire logic        mclk_pin,
   input  wire logic        sclk_pin,
   input  wire logic        lrclk_pin,
   // Event sources
   input  wire logic        fault_pin,
   input  wire logic        clip_evt,
   input  wire logic        vol_ramp_done,
   // Control outputs to the audio path
   output logic             dc_block_en,
   output logic [1:0]       deemph_sel,
   output acs_fmt_s         ser_fmt,
   output logic             clk_err_mute,
   output logic             unmute_soft,
   output logic             unmute_start
);

   // Pin synchronisers, one per pin
   localparam int NPIN = 4;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;
   logic [NPIN-1:0] prev_q;
   logic [NPIN-1:0] rise;

   assign pin_raw = {fault_pin, lrclk_pin, sclk_pin, mclk_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               prev_q[gi]  <= 1'b0;
            end else begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               prev_q[gi]  <= sync2_q[gi];
            end
         end
         assign rise[gi] = sync2_q[gi] && !prev_q[gi];
      end
   endgenerate

   // Event names
   logic mclk_rise;
   logic sclk_rise;
   logic frame;
   logic fault_lvl;

   assign mclk_rise = rise[0];
   assign sclk_rise = rise[1];
   assign frame     = rise[2];
   assign fault_lvl = sync2_q[3];

   // Per-frame counts of master clocks, bit clocks and system clocks
   logic [CNT_W-1:0] mclk_cnt;
   logic [CNT_W-1:0] sclk_cnt;
   logic [CNT_W-1:0] sys_cnt;
   logic             meas_done;

   acs_clk_meter u_mclk_meter (
      .clock (clock),
      .rst_n (rst_n),
      .tick  (mclk_rise),
      .frame (frame),
      .count (mclk_cnt),
      .done  (meas_done)
   );

   acs_clk_meter u_sclk_meter (
      .clock (clock),
      .rst_n (rst_n),
      .tick  (sclk_rise),
      .frame (frame),
      .count (sclk_cnt),
      .done  ()
   );

   acs_clk_meter u_sys_meter (
      .clock (clock),
      .rst_n (rst_n),
      .tick  (1'b1),
      .frame (frame),
      .count (sys_cnt),
      .done  ()
   );

   // Previous frame counts and a valid marker after two frames
   logic [CNT_W-1:0] mclk_prev_q;
   logic [CNT_W-1:0] sclk_prev_q;
   logic [CNT_W-1:0] sys_prev_q;
   logic [1:0]       frames_q;
   logic             meas_ok;

   assign meas_ok = frames_q[1];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mclk_prev_q <= '0;
         sclk_prev_q <= '0;
         sys_prev_q  <= '0;
         frames_q    <= 2'h0;
      end else if (meas_done) begin
         mclk_prev_q <= mclk_cnt;
         sclk_prev_q <= sclk_cnt;
         sys_prev_q  <= sys_cnt;
         frames_q    <= {frames_q[0], 1'b1};
      end
   end

   // Absolute differences between frames
   logic [CNT_W-1:0] mclk_diff;
   logic [CNT_W-1:0] sys_diff;
   logic             mclk_chg;
   logic             sclk_chg;
   logic             lrclk_chg;

   assign mclk_diff = (mclk_cnt > mclk_prev_q) ? mclk_cnt - mclk_prev_q : mclk_prev_q - mclk_cnt;
   assign sys_diff  = (sys_cnt > sys_prev_q) ? sys_cnt - sys_prev_q : sys_prev_q - sys_cnt;
   assign mclk_chg  = meas_done && meas_ok && (mclk_diff > RATIO_TOL);
   assign sclk_chg  = meas_done && meas_ok && (sclk_cnt != sclk_prev_q);
   assign lrclk_chg = meas_done && meas_ok && (sys_diff > FS_TOL);

   // Sample rate from the word clock period
   logic [2:0] rate_code;
   assign rate_code = (sys_cnt < FS_LIM_48K) ? RATE_48K :
                      (sys_cnt < FS_LIM_32K) ? RATE_32K :
                      (sys_cnt < FS_LIM_24K) ? RATE_24K :
                      (sys_cnt < FS_LIM_16K) ? RATE_16K :
                      (sys_cnt < FS_LIM_12K) ? RATE_12K :
                      (sys_cnt < FS_LIM_8K)  ? RATE_8K  :
                      (sys_cnt < FS_MIN_8K)  ? RATE_8K  : RATE_NONE;

   // Master clock ratio from clocks per word
   function automatic logic near_cnt(input logic [CNT_W-1:0] val, input logic [CNT_W-1:0] ref_val);
      logic [CNT_W-1:0] lo;
      lo = ref_val - RATIO_TOL;
      near_cnt = (val >= lo) && (val <= ref_val + RATIO_TOL);
   endfunction

   logic [2:0] ratio_code;
   assign ratio_code = near_cnt(mclk_cnt, 14'd64)  ? RATIO_64  :
                       near_cnt(mclk_cnt, 14'd128) ? RATIO_128 :
                       near_cnt(mclk_cnt, 14'd192) ? RATIO_192 :
                       near_cnt(mclk_cnt, 14'd256) ? RATIO_256 :
                       near_cnt(mclk_cnt, 14'd384) ? RATIO_384 :
                       near_cnt(mclk_cnt, 14'd512) ? RATIO_512 : RATIO_BAD;

   // Unsupported or unrecognised clock combinations fail the autolock
   logic combo_bad;
   logic lock_err;

   assign combo_bad = ((ratio_code == RATIO_64 || ratio_code == RATIO_128) && rate_code != RATE_48K)
                   || (ratio_code == RATIO_192 && rate_code != RATE_48K && rate_code != RATE_32K)
                   || ratio_code == RATIO_BAD || rate_code == RATE_NONE;
   assign lock_err  = meas_done && meas_ok && combo_bad;

   // Internal frame sync free-runs on the last period, realigns after a slip
   logic [CNT_W-1:0] fsync_q;
   logic [CNT_W-1:0] slip_lo;
   logic             slip_evt;

   assign slip_lo  = sys_prev_q - SLIP_TOL;
   assign slip_evt = frame && meas_ok && !lrclk_chg
                  && (fsync_q > SLIP_TOL) && (fsync_q < slip_lo);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fsync_q <= '0;
      end else if (frame && (!meas_ok || slip_evt)) begin
         fsync_q <= 14'h0001;
      end else if (fsync_q + 14'h0001 >= sys_prev_q && meas_ok) begin
         fsync_q <= '0;
      end else begin
         fsync_q <= fsync_q + 14'h0001;
      end
   end

   // Clock status register, refreshed on every good frame
   logic [7:0] clk_status_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clk_status_q <= CLK_STATUS_RST;
      end else if (meas_done && meas_ok && !combo_bad) begin
         clk_status_q <= {rate_code, ratio_code, 2'b00};
      end
   end

   // Write strobes; read-only registers have none
   logic wr_err;
   logic wr_ctl;
   logic wr_fmt;

   assign wr_err = req.wr && (req.addr == ADDR_ERR_FLAGS);
   assign wr_ctl = req.wr && (req.addr == ADDR_SYS_CTRL1);
   assign wr_fmt = req.wr && (req.addr == ADDR_SER_FMT);

   // Hardware error events in register bit order
   logic [7:0] err_set;
   logic [7:0] err_keep;
   logic [7:0] err_flags_q;

   assign err_set  = {mclk_chg, lock_err, sclk_chg, lrclk_chg, slip_evt, clip_evt, fault_lvl, 1'b0};
   assign err_keep = wr_err ? (err_flags_q & req.wdata) : err_flags_q;

   // Sticky flags; set wins over a clearing write
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         err_flags_q <= ERR_FLAGS_RST;
      end else begin
         err_flags_q <= (err_keep | err_set) & ERR_FLAGS_MASK;
      end
   end

   // System control and serial format registers
   logic [7:0] sys_ctrl1_q;
   logic [7:0] ser_fmt_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sys_ctrl1_q <= SYS_CTRL1_RST;
         ser_fmt_q   <= SER_FMT_RST;
      end else begin
         if (wr_ctl) begin
            sys_ctrl1_q <= req.wdata & SYS_CTRL1_MASK;
         end
         if (wr_fmt) begin
            ser_fmt_q <= req.wdata & SER_FMT_MASK;
         end
      end
   end

   assign dc_block_en = sys_ctrl1_q[CTL_DCBLK];
   assign deemph_sel  = sys_ctrl1_q[1:0];

   // Serial format decode
   logic [3:0] fmt_code;
   logic [1:0] fmt_len;

   assign fmt_code = ser_fmt_q[3:0];
   assign fmt_len  = (fmt_code > 4'h8) ? 2'h0 : 2'(fmt_code % 4'h3);
   assign ser_fmt.valid    = (fmt_code <= 4'h8);
   assign ser_fmt.just     = (fmt_code <= 4'h2) ? ACS_JUST_RIGHT :
                             (fmt_code <= 4'h5) ? ACS_JUST_I2S   :
                             (fmt_code <= 4'h8) ? ACS_JUST_LEFT  : ACS_JUST_NONE;
   assign ser_fmt.word_len = (fmt_len == 2'h0) ? 5'd16 :
                             (fmt_len == 2'h1) ? 5'd20 : 5'd24;

   // Recovery after a clock error: mute, then soft or hard unmute
   acs_mute_e  mute_q;
   acs_mute_e  mute_d;
   logic       clk_err_evt;

   assign clk_err_evt = mclk_chg | lock_err | sclk_chg | lrclk_chg | slip_evt;

   always_comb begin
      mute_d = mute_q;
      case (mute_q)
         ACS_RUN: begin
            if (clk_err_evt) begin
               mute_d = ACS_MUTE;
            end
         end
         ACS_MUTE: begin
            if (meas_done && meas_ok && !clk_err_evt) begin
               mute_d = sys_ctrl1_q[CTL_HARD] ? ACS_RUN : ACS_RAMP;
            end
         end
         ACS_RAMP: begin
            if (clk_err_evt) begin
               mute_d = ACS_MUTE;
            end else if (vol_ramp_done) begin
               mute_d = ACS_RUN;
            end
         end
         default: begin
            mute_d = ACS_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mute_q       <= ACS_RUN;
         unmute_start <= 1'b0;
      end else begin
         mute_q       <= mute_d;
         unmute_start <= (mute_q == ACS_MUTE) && (mute_d != ACS_MUTE);
      end
   end

   assign clk_err_mute = (mute_q == ACS_MUTE);
   assign unmute_soft  = (mute_q == ACS_RAMP);

   // Read data select; unmapped addresses read zero
   logic [7:0] rd_sel;
   assign rd_sel = (req.addr == ADDR_CLK_STATUS) ? clk_status_q :
                   (req.addr == ADDR_FW_REV)     ? FW_REV_CODE  :
                   (req.addr == ADDR_ERR_FLAGS)  ? err_flags_q  :
                   (req.addr == ADDR_SYS_CTRL1)  ? sys_ctrl1_q  :
                   (req.addr == ADDR_SER_FMT)    ? ser_fmt_q    : 8'h00;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         rdata <= rd_sel;
      end
   end

endmodule

/* acs_pkg.sv */
// Package for the audio clock status and control register bank
package acs_pkg;

   // Register offsets on the serial control port
   localparam logic [7:0] ADDR_CLK_STATUS = 8'h00;
   localparam logic [7:0] ADDR_FW_REV     = 8'h01;
   localparam logic [7:0] ADDR_ERR_FLAGS  = 8'h02;
   localparam logic [7:0] ADDR_SYS_CTRL1  = 8'h03;
   localparam logic [7:0] ADDR_SER_FMT    = 8'h04;

   // Identification code, arbitrary neutral value
   localparam logic [7:0] FW_REV_CODE = 8'hA5;

   // Reset values
   localparam logic [7:0] CLK_STATUS_RST = 8'h6C;
   localparam logic [7:0] ERR_FLAGS_RST  = 8'h00;
   localparam logic [7:0] SYS_CTRL1_RST  = 8'h80;
   localparam logic [7:0] SER_FMT_RST    = 8'h05;

   // Field positions
   localparam int RATE_LSB   = 5;
   localparam int RATIO_LSB  = 2;
   localparam int ERR_MCLK   = 7;
   localparam int ERR_PLL    = 6;
   localparam int ERR_SCLK   = 5;
   localparam int ERR_LRCLK  = 4;
   localparam int ERR_SLIP   = 3;
   localparam int ERR_CLIP   = 2;
   localparam int ERR_PROT   = 1;
   localparam int CTL_DCBLK  = 7;
   localparam int CTL_HARD   = 5;
   localparam logic [7:0] ERR_FLAGS_MASK = 8'hFE;
   localparam logic [7:0] SYS_CTRL1_MASK = 8'hA3;
   localparam logic [7:0] SER_FMT_MASK   = 8'h0F;

   // Sample rate codes
   localparam logic [2:0] RATE_32K  = 3'h0;
   localparam logic [2:0] RATE_48K  = 3'h3;
   localparam logic [2:0] RATE_16K  = 3'h4;
   localparam logic [2:0] RATE_24K  = 3'h5;
   localparam logic [2:0] RATE_8K   = 3'h6;
   localparam logic [2:0] RATE_12K  = 3'h7;
   localparam logic [2:0] RATE_NONE = 3'h1;

   // Master clock ratio codes and counts per word clock
   localparam logic [2:0] RATIO_64  = 3'h0;
   localparam logic [2:0] RATIO_128 = 3'h1;
   localparam logic [2:0] RATIO_192 = 3'h2;
   localparam logic [2:0] RATIO_256 = 3'h3;
   localparam logic [2:0] RATIO_384 = 3'h4;
   localparam logic [2:0] RATIO_512 = 3'h5;
   localparam logic [2:0] RATIO_BAD = 3'h6;

   // Timing
   localparam int CLK_HZ      = 50_000_000;
   localparam int CNT_W       = 14;
   localparam logic [CNT_W-1:0] RATIO_TOL = 14'h0002;
   localparam logic [CNT_W-1:0] FS_TOL    = 14'h0004;
   localparam logic [CNT_W-1:0] SLIP_TOL  = 14'h0004;
   // Word clock periods in system clocks, boundaries between rates
   localparam logic [CNT_W-1:0] FS_LIM_48K = 14'(CLK_HZ / 40_000);
   localparam logic [CNT_W-1:0] FS_LIM_32K = 14'(CLK_HZ / 28_000);
   localparam logic [CNT_W-1:0] FS_LIM_24K = 14'(CLK_HZ / 19_000);
   localparam logic [CNT_W-1:0] FS_LIM_16K = 14'(CLK_HZ / 14_000);
   localparam logic [CNT_W-1:0] FS_LIM_12K = 14'(CLK_HZ / 10_000);
   localparam logic [CNT_W-1:0] FS_LIM_8K  = 14'(CLK_HZ / 7_000);
   localparam logic [CNT_W-1:0] FS_MIN_8K  = 14'(CLK_HZ / 6_000);

   // Coefficient number format, signed 3.23
   localparam int COEF_INT_BITS  = 3;
   localparam int COEF_FRAC_BITS = 23;
   typedef logic signed [COEF_INT_BITS+COEF_FRAC_BITS-1:0] acs_coef_t;

   // Serial audio formats
   typedef enum logic [1:0] {
      ACS_JUST_RIGHT = 2'b00,
      ACS_JUST_I2S   = 2'b01,
      ACS_JUST_LEFT  = 2'b10,
      ACS_JUST_NONE  = 2'b11
   } acs_just_e;

   // Register access from the serial control port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acs_req_s;

   // Decoded serial format
   typedef struct packed {
      acs_just_e  just;
      logic [4:0] word_len;
      logic       valid;
   } acs_fmt_s;

   // Recovery mute state
   typedef enum logic [1:0] {
      ACS_RUN  = 2'b00,
      ACS_MUTE = 2'b01,
      ACS_RAMP = 2'b10
   } acs_mute_e;

endpackage

/* acs_clk_meter.sv */
// Counts qualifying events between word clock rising edges
`timescale 1ns/1ps
module acs_clk_meter
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Events
   input  wire logic             tick,
   input  wire logic             frame,
   // Result
   output logic [CNT_W-1:0]      count,
   output logic                  done
);

   logic [CNT_W-1:0] run_q;
   logic [CNT_W-1:0] run_d;
   logic             sat;

   // Counter saturates rather than wrapping
   assign sat   = &run_q;
   assign run_d = frame ? CNT_W'(tick) : ((tick && !sat) ? run_q + 14'h0001 : run_q);

   // Running count, latched at each frame
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= '0;
         count <= '0;
         done  <= 1'b0;
      end else begin
         run_q <= run_d;
         done  <= frame;
         if (frame) begin
            count <= run_q;
         end
      end
   end

endmodule

/* acs_regs_chk.sv */
// Assertion checker for the clock status and control register bank
`timescale 1ns/1ps
module acs_regs_chk
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst_n,
   // Register port
   input wire acs_req_s   req,
   input wire logic [7:0] rdata,
   // Audio clocks and events
   input wire logic       mclk_pin,
   input wire logic       sclk_pin,
   input wire logic       lrclk_pin,
   input wire logic       fault_pin,
   input wire logic       clip_evt,
   input wire logic       vol_ramp_done,
   // Controls to the audio path
   input wire logic       dc_block_en,
   input wire logic [1:0] deemph_sel,
   input wire acs_fmt_s   ser_fmt,
   input wire logic       clk_err_mute,
   input wire logic       unmute_soft,
   input wire logic       unmute_start
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Write strobes of the two control registers
   wire ctl_wr = req.wr && req.addr == ADDR_SYS_CTRL1;
   wire fmt_wr = req.wr && req.addr == ADDR_SER_FMT;

   // Register port relations
   property p_id_read;
      req.rd && req.addr == ADDR_FW_REV |=> rdata == FW_REV_CODE;
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("revision read wrong");
   property p_unmapped;
      req.rd && req.addr > ADDR_SER_FMT |=> rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_dc_blk;
      ctl_wr |=> dc_block_en == $past(req.wdata[CTL_DCBLK]);
   endproperty
   a_dc_blk: assert property (p_dc_blk)
      else $error("dc block enable not written");
   property p_deemph;
      ctl_wr |=> deemph_sel == $past(req.wdata[1:0]);
   endproperty
   a_deemph: assert property (p_deemph)
      else $error("deemphasis select not written");
   property p_ctl_hold;
      !ctl_wr |=> $stable(dc_block_en) && $stable(deemph_sel);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold)
      else $error("control outputs moved without write");
   property p_fmt_i2s24;
      fmt_wr && req.wdata[3:0] == 4'h5 |=> ser_fmt.just == ACS_JUST_I2S && ser_fmt.word_len == 5'd24 && ser_fmt.valid;
   endproperty
   a_fmt_i2s24: assert property (p_fmt_i2s24)
      else $error("format decode wrong");
   property p_fmt_rsv;
      fmt_wr && req.wdata[3:0] > 4'h8 |=> !ser_fmt.valid;
   endproperty
   a_fmt_rsv: assert property (p_fmt_rsv)
      else $error("reserved format marked valid");
   // Recovery after a clock error
   property p_start_once;
      unmute_start |=> !unmute_start;
   endproperty
   a_start_once: assert property (p_start_once)
      else $error("unmute start longer than one cycle");
   property p_ramp_end;
      unmute_soft && vol_ramp_done |=> !unmute_soft;
   endproperty
   a_ramp_end: assert property (p_ramp_end)
      else $error("soft unmute outlasts the ramp");
   // Protection fault shows in the error register
   property p_fault_flag;
      fault_pin [*5] ##1 (req.rd && req.addr == ADDR_ERR_FLAGS) |=> rdata[ERR_PROT];
   endproperty
   a_fault_flag: assert property (p_fault_flag)
      else $error("fault flag missing");
endmodule

/* acs_clk_src.sv */
// Behavioural audio clock source feeding the serial audio clock pins
`timescale 1ns/1ps
module acs_clk_src (
   // Settings from the bench
   input  wire logic        en,
   input  wire logic [15:0] ratio,
   input  wire logic [15:0] half_ns,
   // Audio clocks
   output logic             mclk,
   output logic             sclk,
   output logic             lrclk
);
   int r;
   int h;
   // One whole frame per pass; clocks stand still while disabled
   initial begin
      mclk = 1'b0;
      sclk = 1'b0;
      lrclk = 1'b0;
      forever begin
         if (en !== 1'b1) begin
            mclk = 1'b0;
            sclk = 1'b0;
            lrclk = 1'b0;
            @(posedge en);
         end
         r = int'(ratio);
         h = int'(half_ns);
         for (int i = 0; i < 2 * r; i++) begin
            lrclk = (i < r);
            if (i % (r / 64) == 0) sclk = ~sclk;
            mclk = ~mclk;
            #(h);
         end
      end
   end
endmodule

/* test_audio_clock_status_control_regs.sv */
// Self-checking bench for the clock status and control register bank
`timescale 1ns/1ps
module test_audio_clock_status_control_regs
   import acs_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   acs_req_s    req;
   logic [7:0]  rdata;
   logic        mclk_pin, sclk_pin, lrclk_pin;
   logic        fault_pin, clip_evt, vol_ramp_done;
   logic        dc_block_en;
   logic [1:0]  deemph_sel;
   acs_fmt_s    ser_fmt;
   logic        clk_err_mute, unmute_soft, unmute_start;
   logic        src_en;
   logic [15:0] src_ratio, src_half;
   logic [7:0]  rv;
   int          mismatches, num_checks, n, starts;

   // 50 MHz clock
   always #10 clock = ~clock;

   // Audio clock source and design
   acs_clk_src acs_clk_src_i (.en(src_en), .ratio(src_ratio), .half_ns(src_half),
      .mclk(mclk_pin), .sclk(sclk_pin), .lrclk(lrclk_pin));
   acs_regs acs_regs_i (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
      .mclk_pin(mclk_pin), .sclk_pin(sclk_pin), .lrclk_pin(lrclk_pin), .fault_pin(fault_pin),
      .clip_evt(clip_evt), .vol_ramp_done(vol_ramp_done), .dc_block_en(dc_block_en),
      .deemph_sel(deemph_sel), .ser_fmt(ser_fmt), .clk_err_mute(clk_err_mute),
      .unmute_soft(unmute_soft), .unmute_start(unmute_start));

   // Comparison and verdict
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task final_report;
      if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Register port cycles, one-cycle strobes
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clock);
      req.wr = 1'b0;
   endtask
   task rc(input string w, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clock);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clock);
      req.rd = 1'b0;
      rv = rdata & m;
      chk(w, e, rv);
   endtask
   // Clock source control and waits
   task clocks(input logic [15:0] r, input logic [15:0] h);
      src_ratio = r;
      src_half = h;
      src_en = 1'b1;
   endtask
   task frames(input int k);
      repeat (k) @(posedge lrclk_pin);
      @(negedge clock);
   endtask
   task wait_mute;
      for (n = 0; n < 6000 && clk_err_mute !== 1'b1; n++) @(negedge clock);
      chk("clk_err_mute", 8'h01, {7'h0, clk_err_mute});
   endtask

   // Unmute start pulses, counted mid-cycle
   always @(negedge clock) begin
      if (unmute_start === 1'b1) starts++;
   end

   // Watchdog
   initial begin
      #1_900_000;
      mismatches++;
      final_report();
   end

   // Test sequence
   initial begin
      req = '0;
      fault_pin = 1'b0;
      clip_evt = 1'b0;
      vol_ramp_done = 1'b0;
      src_en = 1'b0;
      src_ratio = 16'd256;
      src_half = 16'd41;
      mismatches = 0;
      num_checks = 0;
      starts = 0;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      // Power-on values
      rc("clock_detect_status", ADDR_CLK_STATUS, 8'hFF, 8'h6C);
      rc("firmware_revision_id", ADDR_FW_REV, 8'hFF, FW_REV_CODE);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'hFF, 8'h00);
      rc("system_control_one", ADDR_SYS_CTRL1, 8'hFF, 8'h80);
      rc("serial_audio_format", ADDR_SER_FMT, 8'hFF, 8'h05);
      chk("ser_fmt", {ACS_JUST_I2S, 5'd24, 1'b1}, ser_fmt);
      chk("dc_block_en", 8'h01, {7'h0, dc_block_en});
      // Read-only and unmapped places
      wr(ADDR_CLK_STATUS, 8'h13);
      wr(ADDR_FW_REV, 8'h5A);
      rc("clock_detect_status", ADDR_CLK_STATUS, 8'hFF, 8'h6C);
      rc("firmware_revision_id", ADDR_FW_REV, 8'hFF, FW_REV_CODE);
      rc("unmapped", 8'h05, 8'hFF, 8'h00);
      // Control register fields
      wr(ADDR_SYS_CTRL1, 8'hFF);
      rc("system_control_one", ADDR_SYS_CTRL1, 8'hFF, 8'hA3);
      for (n = 0; n < 4; n++) begin
         wr(ADDR_SYS_CTRL1, 8'(n));
         chk("deemph_sel", 8'(n), {6'h0, deemph_sel});
         chk("dc_block_en", 8'h00, {7'h0, dc_block_en});
      end
      wr(ADDR_SYS_CTRL1, 8'h80);
      // All serial format codes
      for (n = 0; n < 16; n++) begin
         wr(ADDR_SER_FMT, 8'(n) | 8'hF0);
         rc("serial_audio_format", ADDR_SER_FMT, 8'hFF, 8'(n));
         chk("ser_fmt.valid", 8'(n < 9), {7'h0, ser_fmt.valid});
         if (n < 9) chk("ser_fmt", {2'(n / 3), 5'(16 + 4 * (n % 3)), 1'b1}, ser_fmt);
      end
      wr(ADDR_SER_FMT, 8'h05);
      // Steady 48 kHz at 256x, flags cleared stay clear
      clocks(16'd256, 16'd41);
      frames(5);
      wr(ADDR_ERR_FLAGS, 8'h00);
      frames(2);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'hFF, 8'h00);
      rc("clock_detect_status", ADDR_CLK_STATUS, 8'hFF, 8'h6C);
      // Move to 32 kHz at 192x with soft recovery
      clocks(16'd192, 16'd81);
      wait_mute();
      frames(5);
      rc("clock_detect_status", ADDR_CLK_STATUS, 8'hFF, 8'h08);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'hB8, 8'h98);
      chk("unmute_soft", 8'h01, {7'h0, unmute_soft});
      chk("unmute_start", 8'h01, 8'(starts));
      @(negedge clock) vol_ramp_done = 1'b1;
      @(negedge clock) vol_ramp_done = 1'b0;
      chk("unmute_soft", 8'h00, {7'h0, unmute_soft});
      // Flags survive a ones write, clear on zeroes
      wr(ADDR_ERR_FLAGS, 8'hFF);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'hB0, 8'h90);
      wr(ADDR_ERR_FLAGS, 8'h00);
      frames(2);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'hFF, 8'h00);
      // Back to 48 kHz with hard recovery
      wr(ADDR_SYS_CTRL1, 8'h20);
      clocks(16'd256, 16'd41);
      wait_mute();
      frames(5);
      chk("unmute_soft", 8'h00, {7'h0, unmute_soft});
      chk("clk_err_mute", 8'h00, {7'h0, clk_err_mute});
      chk("unmute_start", 8'h02, 8'(starts));
      rc("clock_detect_status", ADDR_CLK_STATUS, 8'hFF, 8'h6C);
      // Forbidden combinations raise lock error, status kept
      clocks(16'd64, 16'd244);
      frames(4);
      wr(ADDR_ERR_FLAGS, 8'h00);
      frames(2);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'h40, 8'h40);
      rc("clock_detect_status", ADDR_CLK_STATUS, 8'hFF, 8'h6C);
      clocks(16'd192, 16'd162);
      frames(4);
      wr(ADDR_ERR_FLAGS, 8'h00);
      frames(2);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'h40, 8'h40);
      rc("clock_detect_status", ADDR_CLK_STATUS, 8'hFF, 8'h6C);
      // Protection fault and clip events
      @(negedge clock);
      fault_pin = 1'b1;
      clip_evt = 1'b1;
      @(negedge clock) clip_evt = 1'b0;
      repeat (6) @(negedge clock);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'h06, 8'h06);
      fault_pin = 1'b0;
      repeat (5) @(negedge clock);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'h06, 8'h06);
      wr(ADDR_ERR_FLAGS, 8'h00);
      rc("sticky_error_flags", ADDR_ERR_FLAGS, 8'h06, 8'h00);
      final_report();
   end
endmodule

bind acs_regs acs_regs_chk acs_regs_chk_i (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
   .mclk_pin(mclk_pin), .sclk_pin(sclk_pin), .lrclk_pin(lrclk_pin), .fault_pin(fault_pin),
   .clip_evt(clip_evt), .vol_ramp_done(vol_ramp_done), .dc_block_en(dc_block_en),
   .deemph_sel(deemph_sel), .ser_fmt(ser_fmt), .clk_err_mute(clk_err_mute),
   .unmute_soft(unmute_soft), .unmute_start(unmute_start));
